// >>> logic/gam_defs.svh
// Constants for the pin function multiplexer: pin indices, widths and reset values.
`ifndef GAM_DEFS_SVH
`define GAM_DEFS_SVH
// ----------------------------------------
// Pin map
// ----------------------------------------
`define GAM_NPINS 23
`define GAM_NGEN_OUT 8
`define GAM_PIN_IRQ0 8
`define GAM_PIN_FLASH_WE 11
`define GAM_PIN_NV_SDA 12
`define GAM_PIN_NV_SCL 13
`define GAM_PIN_HOST_DATA 16
`define GAM_PIN_HOST_IRQ 21
`define GAM_PIN_HOST_CLK 22
// Pins that offer the open-drain option (0-5, 9-15).
`define GAM_OD_CAPABLE 23'h00FE3F
// ----------------------------------------
// Reset values
// ----------------------------------------
`define GAM_RST_OE 23'h000000
`define GAM_RST_OUT 23'h000000
`define GAM_RST_OD 23'h000000
`define GAM_RST_GEN_OUT 8'h00
`endif

// >>> logic/gam_pkg.sv
// Types shared by the pin function multiplexer.
`default_nettype none
package gam_pkg;
    // Function selected on a multiplexed pin.
    typedef enum logic [1:0] {
        GAM_FN_GPIO,
        GAM_FN_ALT
    } gam_fn_e;
endpackage
`default_nettype wire

// >>> logic/gam_pad.sv
// One bidirectional pad cell: synchroniser and open-drain drive resolution.
`timescale 1ns/1ps
`default_nettype none
module gam_pad (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic pad_in,
    input wire logic drive_en,
    input wire logic drive_val,
    input wire logic open_drain,
    output logic pad_out,
    output logic pad_oe,
    output logic pin_sync
);
    logic meta;
    // Two-stage synchroniser; only the second stage is read.
    // It resets to the pulled-up idle level, because a zero would pose as an
    // interrupt request or a bus start in the first cycles after reset.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            meta <= 1'b1;
            pin_sync <= 1'b1;
        end else begin
            meta <= pad_in;
            pin_sync <= meta;
        end
    end
    // In open-drain mode a high is a release, so the enable follows the low value.
    assign pad_out = open_drain ? 1'b0 : drive_val;
    assign pad_oe = drive_en & (open_drain ? ~drive_val : 1'b1); // R2
endmodule
`default_nettype wire

// >>> logic/gam_mux.sv
// Pin function multiplexer for system-interface and general-purpose pins.
// Operation
// R1 - Pin 8 sampled low is the controller's active-low interrupt zero request and stays GPIO.
// R2 - Pins with the option have a register-selected open-drain mode that drives only low.
// R3 - Pin 11 may serve as active-low flash write strobe, otherwise it is GPIO.
// R4 - Pins 12 and 13 may carry the data and clock of a 2-wire master to nonvolatile memory.
// R5 - With the host port enabled pin 16 is the host serial data line, else GPIO.
// R6 - With the host port enabled the host supplies the serial clock on pin 22, else GPIO.
// R7 - With the host port enabled pin 21 is an open-drain active-low interrupt to the host.
// R8 - Backlight enable and panel power outputs each can be placed in high impedance.
// R9 - Config bits select function, open drain and value; reset leaves every pin an input.
`timescale 1ns/1ps
`default_nettype none
`include "gam_defs.svh"
module gam_mux (
    input wire logic ref_clk,
    input wire logic rstn,
    // Pads.
    input wire logic [22:0] pin_in,
    output logic [22:0] pin_out,
    output logic [22:0] pin_oe,
    output logic [7:0] general_output_line,
    output logic backlight_enable_out,
    output logic backlight_enable_oe,
    output logic panel_power_out,
    output logic panel_power_oe,
    // Configuration, from software.
    input wire logic cfg_load,
    input wire logic [22:0] cfg_oe,
    input wire logic [22:0] cfg_out,
    input wire logic [22:0] cfg_od,
    input wire logic [7:0] cfg_general_output,
    input wire logic cfg_flash_we_en,
    input wire logic cfg_nvmem_en,
    input wire logic cfg_host_en,
    input wire logic cfg_backlight,
    input wire logic cfg_backlight_oe,
    input wire logic cfg_panel_power,
    input wire logic cfg_panel_power_oe,
    // Alternate function sources.
    input wire logic flash_we_n,
    input wire logic nvmem_sda_drive_low,
    input wire logic nvmem_scl_drive_low,
    input wire logic host_sda_drive_low,
    input wire logic host_irq_pending,
    // Status and alternate inputs.
    output logic [22:0] pin_state,
    output logic controller_irq_zero_n,
    output logic nvmem_serial_data,
    output logic nvmem_serial_clock,
    output logic host_serial_data,
    output logic host_serial_clock,
    output logic host_port_active
);
    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    logic [22:0] oe_reg;
    logic [22:0] out_reg;
    logic [22:0] od_reg;
    logic [7:0] general_output_reg;
    logic flash_en;
    logic nv_en;
    logic host_en;
    logic bl;
    logic bl_oe;
    logic pp;
    logic pp_oe;

    // Configuration is captured on a load strobe; reset makes all pins inputs.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            oe_reg <= `GAM_RST_OE; // R9
            out_reg <= `GAM_RST_OUT;
            od_reg <= `GAM_RST_OD;
            general_output_reg <= `GAM_RST_GEN_OUT;
            flash_en <= 1'b0;
            nv_en <= 1'b0;
            host_en <= 1'b0;
            bl <= 1'b0;
            bl_oe <= 1'b0;
            pp <= 1'b0;
            pp_oe <= 1'b0;
        end else if (cfg_load) begin
            oe_reg <= cfg_oe; // R9
            out_reg <= cfg_out;
            od_reg <= cfg_od & `GAM_OD_CAPABLE; // R2
            general_output_reg <= cfg_general_output;
            flash_en <= cfg_flash_we_en;
            nv_en <= cfg_nvmem_en;
            host_en <= cfg_host_en;
            bl <= cfg_backlight;
            bl_oe <= cfg_backlight_oe;
            pp <= cfg_panel_power;
            pp_oe <= cfg_panel_power_oe;
        end
    end

    // ----------------------------------------
    // Function selection
    // ----------------------------------------
    function automatic gam_pkg::gam_fn_e pin_fn(input int idx, input logic fl, input logic nv,
                                                input logic ho);
        pin_fn = gam_pkg::GAM_FN_GPIO;
        if (idx == `GAM_PIN_FLASH_WE && fl) pin_fn = gam_pkg::GAM_FN_ALT;
        if ((idx == `GAM_PIN_NV_SDA || idx == `GAM_PIN_NV_SCL) && nv) pin_fn = gam_pkg::GAM_FN_ALT;
        if ((idx == `GAM_PIN_HOST_DATA || idx == `GAM_PIN_HOST_IRQ ||
             idx == `GAM_PIN_HOST_CLK) && ho) pin_fn = gam_pkg::GAM_FN_ALT;
    endfunction

    logic [22:0] alt_sel;
    logic [22:0] alt_en;
    logic [22:0] alt_val;
    logic [22:0] alt_od;
    logic [22:0] drv_en;
    logic [22:0] drv_val;
    logic [22:0] drv_od;

    // Alternate drive per pin; 2-wire lines and host interrupt are open-drain by nature.
    always_comb begin
        alt_en = '0;
        alt_val = '1;
        alt_od = '0;
        alt_en[`GAM_PIN_FLASH_WE] = 1'b1; // R3
        alt_val[`GAM_PIN_FLASH_WE] = flash_we_n;
        alt_en[`GAM_PIN_NV_SDA] = 1'b1; // R4
        alt_val[`GAM_PIN_NV_SDA] = ~nvmem_sda_drive_low;
        alt_od[`GAM_PIN_NV_SDA] = 1'b1;
        alt_en[`GAM_PIN_NV_SCL] = 1'b1;
        alt_val[`GAM_PIN_NV_SCL] = ~nvmem_scl_drive_low;
        alt_od[`GAM_PIN_NV_SCL] = 1'b1;
        alt_en[`GAM_PIN_HOST_DATA] = 1'b1; // R5
        alt_val[`GAM_PIN_HOST_DATA] = ~host_sda_drive_low;
        alt_od[`GAM_PIN_HOST_DATA] = 1'b1;
        alt_en[`GAM_PIN_HOST_IRQ] = 1'b1; // R7
        alt_val[`GAM_PIN_HOST_IRQ] = ~host_irq_pending;
        alt_od[`GAM_PIN_HOST_IRQ] = 1'b1;
        // The host clock pin is input only while the host port owns it.
        alt_en[`GAM_PIN_HOST_CLK] = 1'b0; // R6
    end

    // ----------------------------------------
    // Pad cells
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < `GAM_NPINS; g++) begin : g_pin
            assign alt_sel[g] = (pin_fn(g, flash_en, nv_en, host_en) == gam_pkg::GAM_FN_ALT);
            assign drv_en[g] = alt_sel[g] ? alt_en[g] : oe_reg[g];
            assign drv_val[g] = alt_sel[g] ? alt_val[g] : out_reg[g];
            assign drv_od[g] = alt_sel[g] ? alt_od[g] : od_reg[g];
            gam_pad u_pad (
                .ref_clk(ref_clk),
                .rstn(rstn),
                .pad_in(pin_in[g]),
                .drive_en(drv_en[g]),
                .drive_val(drv_val[g]),
                .open_drain(drv_od[g]),
                .pad_out(pin_out[g]),
                .pad_oe(pin_oe[g]),
                .pin_sync(pin_state[g])
            );
        end
    endgenerate

    // ----------------------------------------
    // Alternate inputs and plain outputs
    // ----------------------------------------
    // Pin 8 feeds the interrupt directly with no function switch, so GPIO use stays intact.
    assign controller_irq_zero_n = pin_state[`GAM_PIN_IRQ0]; // R1
    assign nvmem_serial_data = pin_state[`GAM_PIN_NV_SDA]; // R4
    assign nvmem_serial_clock = pin_state[`GAM_PIN_NV_SCL];
    // Host lines idle high when the port is off so the serial engine sees no activity.
    assign host_serial_data = host_en ? pin_state[`GAM_PIN_HOST_DATA] : 1'b1; // R5
    assign host_serial_clock = host_en ? pin_state[`GAM_PIN_HOST_CLK] : 1'b1; // R6
    assign host_port_active = host_en;
    assign general_output_line = general_output_reg;
    assign backlight_enable_out = bl;
    assign backlight_enable_oe = bl_oe; // R8
    assign panel_power_out = pp;
    assign panel_power_oe = pp_oe; // R8

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_irq_follow;
        @(posedge ref_clk) disable iff (!rstn)
        $fell(pin_in[`GAM_PIN_IRQ0]) ##2 1'b1 |-> ##0 !controller_irq_zero_n;
    endproperty
    a_irq_follow: assert property (p_irq_follow) else $error("irq zero did not follow pin"); // R1

    property p_od_no_high;
        @(posedge ref_clk) disable iff (!rstn)
        (od_reg[9] && !alt_sel[9]) |-> !(pin_oe[9] && pin_out[9]);
    endproperty
    a_od_no_high: assert property (p_od_no_high) else $error("open-drain pin drove high"); // R2

    property p_flash_we;
        @(posedge ref_clk) disable iff (!rstn)
        flash_en |-> (pin_oe[`GAM_PIN_FLASH_WE] && pin_out[`GAM_PIN_FLASH_WE] == flash_we_n);
    endproperty
    a_flash_we: assert property (p_flash_we) else $error("flash strobe not on pin"); // R3

    property p_nv_sda;
        @(posedge ref_clk) disable iff (!rstn)
        nv_en |-> (pin_oe[`GAM_PIN_NV_SDA] == nvmem_sda_drive_low && !pin_out[`GAM_PIN_NV_SDA]);
    endproperty
    a_nv_sda: assert property (p_nv_sda) else $error("nvmem data not driven open-drain"); // R4

    property p_host_data;
        @(posedge ref_clk) disable iff (!rstn)
        host_en |-> (pin_oe[`GAM_PIN_HOST_DATA] == host_sda_drive_low);
    endproperty
    a_host_data: assert property (p_host_data) else $error("host data drive wrong"); // R5

    property p_host_clk;
        @(posedge ref_clk) disable iff (!rstn)
        host_en |-> !pin_oe[`GAM_PIN_HOST_CLK];
    endproperty
    a_host_clk: assert property (p_host_clk) else $error("device drove host clock"); // R6

    property p_host_irq;
        @(posedge ref_clk) disable iff (!rstn)
        host_en |-> (pin_oe[`GAM_PIN_HOST_IRQ] == host_irq_pending && !pin_out[`GAM_PIN_HOST_IRQ]);
    endproperty
    a_host_irq: assert property (p_host_irq) else $error("host interrupt drive wrong"); // R7

    property p_cfg_load;
        @(posedge ref_clk) disable iff (!rstn)
        (cfg_load && !cfg_flash_we_en && !cfg_nvmem_en && !cfg_host_en)
            |=> (pin_oe == ($past(cfg_oe) & ~($past(cfg_od) & $past(cfg_out) & `GAM_OD_CAPABLE))
                 && general_output_line == $past(cfg_general_output));
    endproperty
    a_cfg_load: assert property (p_cfg_load) else $error("gpio config not applied"); // R9
endmodule
`default_nettype wire

// >>> bench/gam_host_model.sv
// Behavioural host on the 2-wire serial port: clock source and data pull-down.
`timescale 1ns/1ps
`default_nettype none
module gam_host_model (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic run,
    input wire logic send_low,
    output logic scl_low,
    output logic sda_low
);
    // ----------------------------------------
    // Clock and data
    // ----------------------------------------
    logic [2:0] div;
    // The clock stands released between frames, and data moves only while it is low.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            div <= 3'h0;
            scl_low <= 1'b0;
            sda_low <= 1'b0;
        end else begin
            div <= run ? div + 3'h1 : 3'h0;
            if (run && div == 3'h7) scl_low <= ~scl_low;
            else if (!run) scl_low <= 1'b0;
            // Outside a frame the host lets go of the data line as well.
            if (!run) sda_low <= 1'b0;
            else if (scl_low) sda_low <= send_low;
        end
    end
endmodule
`default_nettype wire

// >>> bench/gam_mux_tb.sv
// Self-checking bench for the pin function multiplexer.
`timescale 1ns/1ps
`default_nettype none
`include "gam_defs.svh"
module gam_mux_tb;
    // ----------------------------------------
    // Stimulus and wiring
    // ----------------------------------------
    logic ref_clk = 1'b0, rstn = 1'b0, cfg_load = 1'b0, run = 1'b0, send_low = 1'b0;
    logic [22:0] cfg_oe = '0, cfg_out = '0, cfg_od = '0, ext_low = '0;
    logic [7:0] cfg_gen_out = '0;
    logic fwe = 1'b0, nve = 1'b0, hen = 1'b0, bl = 1'b0, bl_oe = 1'b0, pp = 1'b0, pp_oe = 1'b0;
    logic flash_we_n = 1'b1, nv_sda = 1'b0, nv_scl = 1'b0, h_sda = 1'b0, h_irq = 1'b0;
    logic [22:0] pin_out, pin_oe, pin_state, lvl;
    logic [7:0] gen_out;
    logic blo, bloe, ppo, ppoe, irq0, nvd, nvc, hsd, hsc, hact, scl_low, sda_low;
    int n_fail = 0, check_count = 0, cyc = 0;
    // Open-drain wired-AND with pull-ups: any party pulling low wins.
    assign lvl = ~((pin_oe & ~pin_out) | ext_low | {scl_low, 5'h00, sda_low, 16'h0000});
    always #2 ref_clk = ~ref_clk;
    gam_mux uut (.ref_clk(ref_clk), .rstn(rstn), .pin_in(lvl), .pin_out(pin_out),
        .pin_oe(pin_oe), .general_output_line(gen_out), .backlight_enable_out(blo),
        .backlight_enable_oe(bloe), .panel_power_out(ppo), .panel_power_oe(ppoe),
        .cfg_load(cfg_load), .cfg_oe(cfg_oe), .cfg_out(cfg_out), .cfg_od(cfg_od),
        .cfg_general_output(cfg_gen_out), .cfg_flash_we_en(fwe), .cfg_nvmem_en(nve),
        .cfg_host_en(hen),
        .cfg_backlight(bl), .cfg_backlight_oe(bl_oe), .cfg_panel_power(pp),
        .cfg_panel_power_oe(pp_oe), .flash_we_n(flash_we_n), .nvmem_sda_drive_low(nv_sda),
        .nvmem_scl_drive_low(nv_scl), .host_sda_drive_low(h_sda),
        .host_irq_pending(h_irq), .pin_state(pin_state), .controller_irq_zero_n(irq0),
        .nvmem_serial_data(nvd), .nvmem_serial_clock(nvc), .host_serial_data(hsd),
        .host_serial_clock(hsc), .host_port_active(hact));
    gam_host_model host (.ref_clk(ref_clk), .rstn(rstn), .run(run), .send_low(send_low),
        .scl_low(scl_low), .sda_low(sda_low));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input logic [22:0] got, input logic [22:0] exp, input string m);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask
    // Pulse the load strobe for one edge, then let one more edge pass.
    // The spare edge keeps back-to-back loads from rewriting the strobe in one time step.
    task automatic load();
        cfg_load = 1'b1;
        @(negedge ref_clk);
        cfg_load = 1'b0;
        @(negedge ref_clk);
    endtask
    task automatic wait_sync();
        repeat (3) @(negedge ref_clk);
    endtask
    task automatic conclude();
        if (n_fail == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // A hang is cut short well beyond the length of the sequence.
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            conclude();
        end
    end
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        repeat (10) @(negedge ref_clk);
        chk(pin_oe, 23'h000000, "reset oe");
        chk(23'({bloe, ppoe, hact, gen_out}), 23'h000000, "reset misc");
        chk(pin_state, 23'h7FFFFF, "reset pin state");
        chk(23'(irq0), 23'h000001, "reset irq zero idle");
        rstn = 1'b1;
        cfg_oe = 23'h7FFFFF;
        cfg_out = 23'h5A3C96;
        cfg_gen_out = 8'hA5;
        load();
        chk(pin_oe, 23'h7FFFFF, "gpio oe");
        chk(pin_out, 23'h5A3C96, "gpio out");
        chk(23'(gen_out), 23'h0000A5, "general outputs");
        cfg_od = 23'h7FFFFF;
        load();
        chk(pin_out, 23'h5A3C96 & ~`GAM_OD_CAPABLE, "od out");
        chk(pin_oe, ~`GAM_OD_CAPABLE | ~23'h5A3C96, "od oe");
        cfg_oe = 23'h000000;
        cfg_od = 23'h000000;
        load();
        wait_sync();
        chk(23'(irq0), 23'h000001, "irq zero idle");
        // The interrupt follows the pin two edges after it falls.
        ext_low[8] = 1'b1;
        @(negedge ref_clk);
        chk(23'(irq0), 23'h000001, "irq zero after one edge");
        @(negedge ref_clk);
        chk(23'(irq0), 23'h000000, "irq zero");
        chk(23'(pin_state[8]), 23'h000000, "irq pin state");
        ext_low[8] = 1'b0;
        ext_low[13] = 1'b1;
        fwe = 1'b1;
        nve = 1'b1;
        flash_we_n = 1'b0;
        nv_sda = 1'b1;
        nv_scl = 1'b1;
        load();
        chk(23'({pin_oe[11], pin_out[11]}), 23'h000002, "strobe low");
        chk(23'({pin_oe[12], pin_out[12]}), 23'h000002, "nvmem data low");
        chk(23'({pin_oe[13], pin_out[13]}), 23'h000002, "nvmem clock low");
        flash_we_n = 1'b1;
        nv_sda = 1'b0;
        nv_scl = 1'b0;
        wait_sync();
        chk(23'({pin_oe[11], pin_out[11]}), 23'h000003, "strobe high");
        chk(23'({pin_oe[12], pin_oe[13]}), 23'h000000, "nvmem lines released");
        chk(23'({nvd, nvc}), 23'h000002, "nvmem lines in");
        ext_low[13] = 1'b0;
        fwe = 1'b0;
        nve = 1'b0;
        hen = 1'b1;
        h_irq = 1'b1;
        h_sda = 1'b1;
        bl = 1'b1;
        bl_oe = 1'b1;
        pp = 1'b0;
        pp_oe = 1'b1;
        load();
        chk(23'({bloe, blo, ppoe, ppo}), 23'h00000E, "panel drive");
        chk(23'(pin_oe[11]), 23'h000000, "strobe pin back to gpio");
        chk(23'({pin_oe[21], pin_out[21]}), 23'h000002, "host irq pull");
        chk(23'({pin_oe[16], pin_out[16]}), 23'h000002, "host data pull");
        chk(23'(hact), 23'h000001, "host active");
        h_irq = 1'b0;
        h_sda = 1'b0;
        wait_sync();
        chk(23'({hsd, hsc, pin_oe[21], pin_oe[16]}), 23'h00000C, "host lines released");
        send_low = 1'b1;
        run = 1'b1;
        @(posedge scl_low);
        wait_sync();
        chk(23'({hsc, pin_oe[22]}), 23'h000000, "host clock low");
        @(negedge scl_low);
        wait_sync();
        chk(23'({hsc, pin_oe[22]}), 23'h000002, "host clock high");
        @(posedge scl_low);
        wait_sync();
        chk(23'(hsd), 23'h000000, "host data in");
        run = 1'b0;
        hen = 1'b0;
        bl_oe = 1'b0;
        pp_oe = 1'b0;
        cfg_oe = 23'h610000;
        cfg_out = 23'h610000;
        load();
        chk(23'({bloe, ppoe, hact}), 23'h000000, "disabled");
        chk(pin_oe & 23'h610000, 23'h610000, "host pins gpio oe");
        chk(pin_out & 23'h610000, 23'h610000, "host pins gpio out");
        wait_sync();
        chk(23'({hsd, hsc}), 23'h000003, "host idle");
        chk(pin_state & 23'h610000, 23'h610000, "host pins high");
        // A second reset in mid-run must make every pin an input again.
        rstn = 1'b0;
        @(negedge ref_clk);
        chk(pin_oe, 23'h000000, "second reset oe");
        chk(23'({bloe, ppoe, hact, gen_out}), 23'h000000, "second reset misc");
        chk(pin_state, 23'h7FFFFF, "second reset pin state");
        rstn = 1'b1;
        @(negedge ref_clk);
        chk(pin_oe, 23'h000000, "after reset oe");
        conclude();
    end
endmodule
`default_nettype wire
